// ===== pfbs_pkg.sv
// Constants and types for the program fetch bus select block
package pfbs_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_PORTS   = 7;
  localparam int unsigned NUM_REQ     = 3;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned IRAM_DEPTH  = 256;
  localparam logic [7:0]  PORT_RESET  = 8'hff;
  localparam logic [7:0]  SFR_BASE    = 8'h80;
  localparam logic [7:0]  BANK_TOP    = 8'h1f;

  // Port indices
  localparam logic [2:0]  PORT_ZERO   = 3'h0;
  localparam logic [2:0]  PORT_TWO    = 3'h2;
  localparam logic [2:0]  PORT_THREE  = 3'h3;
  localparam logic [2:0]  PORT_FIVE   = 3'h5;
  localparam logic [2:0]  PORT_SIX    = 3'h6;
  localparam int unsigned WR_PIN      = 6;
  localparam int unsigned RD_PIN      = 7;

  // Requester indices, lowest index wins
  localparam int unsigned REQ_DMA0    = 0;
  localparam int unsigned REQ_DMA1    = 1;
  localparam int unsigned REQ_CPU     = 2;

  // Split point of the alternate program window
  localparam logic [15:0] ALT_WINDOW_TOP = 16'h1fff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned OSC_PER_MCYCLE = 12;
  localparam int unsigned RESET_MCYCLES  = 3;
  localparam int unsigned STROBE_CYCLES  = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ALE  = 4'h2,
    ST_STRB = 4'h4,
    ST_DONE = 4'h8
  } pfbs_state_e;

  typedef enum logic [1:0] {
    RGN_BANKS = 2'h0,
    RGN_RAM   = 2'h1,
    RGN_SFR   = 2'h2
  } pfbs_region_e;

endpackage

// ===== pfbs_top.sv
// External memory bus front end with fetch port selection
// Contract
// - Reset enters after reset pin held low three machine cycles; source holds it.
// - Serial channel unit may finish a transmission already under way at reset.
// - Alternate bus select 1 uses the alternate fetch strobe for program reads; code does so seven-port only, and only for 0h-1FFFh if access 1.
// - Alternate bus select 0 uses the main fetch strobe for program reads.
// - Address latch strobe pulses to capture low address; latch holds it.
// - Five-port variant ignores external access; all fetches via ports zero/two.
// - Seven-port, select 0, access 0: all fetches via ports zero/two, main strobe.
// - Seven-port, select 1, access 0: all fetches via ports five/six, alt strobe.
// - Both 1: 0h-1FFFh via five/six alt; 2000h-FFFFh via zero/two main.
// - Selected pair carries bus: low port address low/data, high port address high.
// - Port pins quasi-bidirectional; written 1 is weak input, written value output.
// - Ports zero to four bit addressable; ports five and six byte only.
// - One requester at a time owns the bus: processor or one DMA channel.
// - Program memory is external, 64K program and 64K data space.
// - Internal data memory is 256 bytes: banks, general RAM and SFR area.
// - Port three pins six and seven are data write and read strobes.
`timescale 1ns/100ps
module pfbs_top #(
  parameter int unsigned MCYCLE_OSC = pfbs_pkg::OSC_PER_MCYCLE,
  parameter int unsigned STRB_CYC   = pfbs_pkg::STROBE_CYCLES
) (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  // Reset pin, straps and serial unit status
  input  wire logic                                reset_pin_n_i,
  input  wire logic                                seven_port_variant_i,
  input  wire logic                                alt_bus_select_i,
  input  wire logic                                ext_access_sel_n_i,
  input  wire logic                                serial_busy_i,
  output logic                                     core_reset_o,
  output logic                                     serial_reset_o,
  // Memory requests from processor and DMA channels
  input  wire logic [pfbs_pkg::NUM_REQ-1:0]        req_i,
  input  wire logic [pfbs_pkg::NUM_REQ-1:0]        req_code_i,
  input  wire logic [pfbs_pkg::NUM_REQ-1:0]        req_we_i,
  input  wire logic [pfbs_pkg::NUM_REQ-1:0][15:0]  req_addr_i,
  input  wire logic [pfbs_pkg::NUM_REQ-1:0][7:0]   req_wdata_i,
  output logic      [pfbs_pkg::NUM_REQ-1:0]        req_grant_o,
  output logic      [pfbs_pkg::NUM_REQ-1:0]        req_done_o,
  output logic      [7:0]                          req_rdata_o,
  // Port latch access
  input  wire logic                                port_wr_i,
  input  wire logic                                port_bit_i,
  input  wire logic [2:0]                          port_sel_i,
  input  wire logic [2:0]                          port_bit_idx_i,
  input  wire logic [7:0]                          port_wdata_i,
  output logic      [7:0]                          port_rdata_o,
  // Internal data memory
  input  wire logic                                iram_we_i,
  input  wire logic [7:0]                          iram_addr_i,
  input  wire logic [7:0]                          iram_wdata_i,
  output logic      [7:0]                          iram_rdata_o,
  output logic      [1:0]                          iram_region_o,
  // Bus strobes
  output logic                                     ale_o,
  output logic                                     main_fetch_strobe_n_o,
  output logic                                     alt_fetch_strobe_n_o,
  // Port pins
  input  wire logic [pfbs_pkg::NUM_PORTS-1:0][7:0] pin_i,
  output logic      [pfbs_pkg::NUM_PORTS-1:0][7:0] pin_o,
  output logic      [pfbs_pkg::NUM_PORTS-1:0][7:0] pin_oe_o
);
  import pfbs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                     osc_cnt;
    logic [1:0]                     low_cnt;
    logic                           core_rst;
    logic                           serial_rst;
    pfbs_state_e                    state;
    logic [7:0]                     strb_cnt;
    logic [NUM_REQ-1:0]             owner;
    logic [15:0]                    addr;
    logic [7:0]                     wdata;
    logic                           code;
    logic                           we;
    logic                           use_alt;
    logic [7:0]                     rdata;
    logic [NUM_REQ-1:0]             done;
    logic [7:0]                     port_rd;
    logic [NUM_PORTS-1:0][7:0]      latch;
    logic [7:0]                     iram_rd;
    logic [IRAM_DEPTH-1:0][7:0]     iram;
  } pfbs_regs_s;

  localparam logic [7:0] MCYC_LAST = 8'(MCYCLE_OSC - 1);
  localparam logic [7:0] STRB_LAST = 8'(STRB_CYC - 1);
  localparam logic [1:0] LOW_LAST  = 2'(RESET_MCYCLES - 1);

  pfbs_regs_s st_reg;
  pfbs_regs_s st_next;
  logic       mcyc_tick;
  logic       grab_alt;
  logic [NUM_REQ-1:0] pick;

  assign mcyc_tick = (st_reg.osc_cnt == MCYC_LAST);

  // ****************************************************************
  // Arbitration and fetch route
  // ****************************************************************
  always_comb begin
    pick = '0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        pick = NUM_REQ'(1) << i;
      end
    end
  end

  always_comb begin
    logic [15:0] a;
    a = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (pick[i]) begin
        a = req_addr_i[i];
      end
    end
    grab_alt = 1'b0;
    if (seven_port_variant_i && alt_bus_select_i) begin
      if (!ext_access_sel_n_i) begin
        grab_alt = 1'b1;
      end else begin
        grab_alt = (a <= ALT_WINDOW_TOP);
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next      = st_reg;
    st_next.done = '0;
    st_next.osc_cnt = mcyc_tick ? 8'h00 : st_reg.osc_cnt + 8'h01;

    // Reset pin filter counted in machine cycles
    if (mcyc_tick) begin
      if (reset_pin_n_i) begin
        st_next.low_cnt  = '0;
        st_next.core_rst = 1'b0;
      end else if (st_reg.low_cnt == LOW_LAST) begin
        st_next.core_rst = 1'b1;
      end else begin
        st_next.low_cnt = st_reg.low_cnt + 2'h1;
      end
    end
    // Serial unit reset waits for a transmission in flight
    st_next.serial_rst = st_reg.core_rst && !serial_busy_i;

    // Port latches
    if (port_wr_i) begin
      if (!port_bit_i) begin
        st_next.latch[port_sel_i] = port_wdata_i;
      end else if (port_sel_i < PORT_FIVE) begin
        st_next.latch[port_sel_i][port_bit_idx_i] = port_wdata_i[0];
      end
    end
    st_next.port_rd = pin_i[port_sel_i];

    // Internal data memory
    if (iram_we_i) begin
      st_next.iram[iram_addr_i] = iram_wdata_i;
    end
    st_next.iram_rd = st_reg.iram[iram_addr_i];

    // External bus sequencer
    case (st_reg.state)
      ST_IDLE: begin
        if (|pick) begin
          st_next.owner   = pick;
          st_next.addr    = req_addr_i[0];
          for (int i = 0; i < NUM_REQ; i++) begin
            if (pick[i]) begin
              st_next.addr  = req_addr_i[i];
              st_next.wdata = req_wdata_i[i];
              st_next.code  = req_code_i[i];
              st_next.we    = req_we_i[i] && !req_code_i[i];
            end
          end
          st_next.use_alt = grab_alt && (|(pick & req_code_i));
          st_next.state   = ST_ALE;
        end
      end
      ST_ALE: begin
        st_next.strb_cnt = '0;
        st_next.state    = ST_STRB;
      end
      ST_STRB: begin
        if (st_reg.strb_cnt == STRB_LAST) begin
          st_next.rdata = st_reg.use_alt ? pin_i[PORT_FIVE]
                                         : pin_i[PORT_ZERO];
          st_next.state = ST_DONE;
        end else begin
          st_next.strb_cnt = st_reg.strb_cnt + 8'h01;
        end
      end
      ST_DONE: begin
        st_next.done  = st_reg.owner;
        st_next.owner = '0;
        st_next.state = ST_IDLE;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    if (st_reg.core_rst) begin
      st_next.state = ST_IDLE;
      st_next.owner = '0;
      st_next.latch = {NUM_PORTS{PORT_RESET}};
    end
  end

  // ****************************************************************
  // Register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg       <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.latch <= {NUM_PORTS{PORT_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic in_strb;
  logic on_bus;
  assign in_strb = (st_reg.state == ST_STRB);
  assign on_bus  = (st_reg.state == ST_ALE) || in_strb;

  assign core_reset_o   = st_reg.core_rst;
  assign serial_reset_o = st_reg.serial_rst;
  assign req_grant_o    = st_reg.owner;
  assign req_done_o     = st_reg.done;
  assign req_rdata_o    = st_reg.rdata;
  assign port_rdata_o   = st_reg.port_rd;
  assign iram_rdata_o   = st_reg.iram_rd;
  assign iram_region_o  = (iram_addr_i >= SFR_BASE)  ? RGN_SFR :
                          (iram_addr_i <= BANK_TOP)  ? RGN_BANKS : RGN_RAM;

  assign ale_o = (st_reg.state == ST_ALE);
  assign main_fetch_strobe_n_o =
    !(in_strb && st_reg.code && !st_reg.use_alt);
  assign alt_fetch_strobe_n_o  =
    !(in_strb && st_reg.code && st_reg.use_alt);

  // Pin drivers, one per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [2:0] PIDX = 3'(p);
    always_comb begin
      logic is_low;
      logic is_high;
      is_low  = on_bus && (PIDX == (st_reg.use_alt ? PORT_FIVE : PORT_ZERO));
      is_high = on_bus && (PIDX == (st_reg.use_alt ? PORT_SIX : PORT_TWO));
      pin_o[p]    = st_reg.latch[p];
      pin_oe_o[p] = ~st_reg.latch[p];
      if (is_low) begin
        if (st_reg.state == ST_ALE) begin
          pin_o[p]    = st_reg.addr[7:0];
          pin_oe_o[p] = 8'hff;
        end else begin
          pin_o[p]    = st_reg.wdata;
          pin_oe_o[p] = {8{st_reg.we}};
        end
      end else if (is_high) begin
        pin_o[p]    = st_reg.addr[15:8];
        pin_oe_o[p] = 8'hff;
      end else if ((PIDX == PORT_THREE) && on_bus && !st_reg.code) begin
        pin_o[p][WR_PIN]    = !(in_strb && st_reg.we);
        pin_o[p][RD_PIN]    = !(in_strb && !st_reg.we);
        pin_oe_o[p][WR_PIN] = 1'b1;
        pin_oe_o[p][RD_PIN] = 1'b1;
      end
      if (!seven_port_variant_i && (PIDX >= PORT_FIVE)) begin
        pin_oe_o[p] = 8'h00;
      end
    end
  end

endmodule // pfbs_top

// ===== pfbs_sva.sv
// Port assertions for the program fetch bus select block
`timescale 1ns/100ps
module pfbs_sva #(
  parameter int unsigned MCYCLE_OSC = 12,
  parameter int unsigned STRB_CYC   = 3
) (
  // Clock, reset and straps
  input wire logic                                mclk_i,
  input wire logic                                rst_i,
  input wire logic                                reset_pin_n_i,
  input wire logic                                seven_port_variant_i,
  input wire logic                                alt_bus_select_i,
  input wire logic                                ext_access_sel_n_i,
  // Observed outputs
  input wire logic                                core_reset_o,
  input wire logic [pfbs_pkg::NUM_REQ-1:0]        req_grant_o,
  input wire logic [pfbs_pkg::NUM_REQ-1:0]        req_done_o,
  input wire logic                                ale_o,
  input wire logic                                main_fetch_strobe_n_o,
  input wire logic                                alt_fetch_strobe_n_o,
  input wire logic [pfbs_pkg::NUM_PORTS-1:0][7:0] pin_oe_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_onehot; $onehot0(req_grant_o); endproperty
  a_onehot: assert property (p_onehot) else $error("two owners");
  property p_done; |req_done_o |-> req_done_o == $past(req_grant_o);
  endproperty
  a_done: assert property (p_done) else $error("done not owner");
  property p_one; main_fetch_strobe_n_o || alt_fetch_strobe_n_o; endproperty
  a_one: assert property (p_one) else $error("both strobes");
  property p_ale;
    $fell(main_fetch_strobe_n_o) || $fell(alt_fetch_strobe_n_o)
      |-> $past(ale_o);
  endproperty
  a_ale: assert property (p_ale) else $error("no latch pulse");
  property p_len;
    $fell(main_fetch_strobe_n_o) |-> (!main_fetch_strobe_n_o)[*3]
      ##1 main_fetch_strobe_n_o;
  endproperty
  a_len: assert property (p_len) else $error("strobe length");
  property p_alt;
    !alt_fetch_strobe_n_o |-> seven_port_variant_i && alt_bus_select_i;
  endproperty
  a_alt: assert property (p_alt) else $error("alt strobe");
  property p_main;
    !main_fetch_strobe_n_o |-> !(seven_port_variant_i && alt_bus_select_i
      && !ext_access_sel_n_i);
  endproperty
  a_main: assert property (p_main) else $error("main strobe");
  property p_five;
    !seven_port_variant_i && !$past(seven_port_variant_i)
      |-> pin_oe_o[5] == 8'h00 && pin_oe_o[6] == 8'h00;
  endproperty
  a_five: assert property (p_five) else $error("port five driven");
  property p_rst;
    $rose(core_reset_o) |-> !$past(reset_pin_n_i)
      && !$past(reset_pin_n_i, 24);
  endproperty
  a_rst: assert property (p_rst) else $error("early reset");
endmodule // pfbs_sva
bind pfbs_top pfbs_sva #(.MCYCLE_OSC(MCYCLE_OSC), .STRB_CYC(STRB_CYC))
  u_pfbs_sva (.mclk_i(mclk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
  .seven_port_variant_i(seven_port_variant_i),
  .alt_bus_select_i(alt_bus_select_i),
  .ext_access_sel_n_i(ext_access_sel_n_i), .core_reset_o(core_reset_o),
  .req_grant_o(req_grant_o), .req_done_o(req_done_o), .ale_o(ale_o),
  .main_fetch_strobe_n_o(main_fetch_strobe_n_o),
  .alt_fetch_strobe_n_o(alt_fetch_strobe_n_o), .pin_oe_o(pin_oe_o));

// ===== pfbs_mem.sv
// External program memory model on both fetch port pairs
`timescale 1ns/100ps
module pfbs_mem (
  // Strobes
  input  wire logic            mclk_i,
  input  wire logic            ale_i,
  input  wire logic            main_n_i,
  input  wire logic            alt_n_i,
  // Pins
  input  wire logic [6:0][7:0] po_i,
  input  wire logic [6:0][7:0] oe_i,
  output logic      [6:0][7:0] pi_o
);
  // ****************************************
  // Address latch and data
  // ****************************************
  logic [7:0] lo0, lo5;
  always_ff @(posedge mclk_i) begin
    if (ale_i) begin
      lo0 <= po_i[0];
      lo5 <= po_i[5];
    end
  end
  always_comb begin
    for (int p = 0; p < 7; p++)
      pi_o[p] = (oe_i[p] & po_i[p]) | ~oe_i[p];
    if (!main_n_i)
      pi_o[0] = lo0 ^ po_i[2] ^ 8'h5a;
    if (!alt_n_i)
      pi_o[5] = lo5 ^ po_i[6] ^ 8'h5a;
    if (oe_i[3][7] && !po_i[3][7])
      pi_o[0] = lo0 ^ po_i[2] ^ 8'ha5;
  end
endmodule // pfbs_mem

// ===== pfbs_top_tb.sv
// Self-checking testbench of the program fetch bus select block
`timescale 1ns/100ps
module pfbs_top_tb;
  import pfbs_pkg::*;
  // ****************************************
  // Signals and tasks
  // ****************************************
  logic mclk_i = 0, rst_i = 1, rpin = 1, sev = 0, alt = 0, ea = 0, busy = 0;
  logic [2:0] req = 0, grant, done, psel = 0, pidx = 0;
  logic [2:0][15:0] addr = '0;
  logic [7:0] rdata, pwd = 0, prd, iad = 0, iwd = 0, ird, v, wd = 0;
  logic pwr = 0, pbit = 0, iwe = 0, crst, srst, ale, mn, an, sm, sa, sw, sr;
  logic [2:0] code = 3'h7, we = 3'h0, g;
  logic [1:0] rgn;
  logic [15:0] a;
  logic [6:0][7:0] pi, po, poe;
  int mismatches = 0, n_checks = 0, seed = 11, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  pfbs_top u_pfbs_top (.mclk_i(mclk_i), .rst_i(rst_i), .reset_pin_n_i(rpin),
    .seven_port_variant_i(sev), .alt_bus_select_i(alt),
    .ext_access_sel_n_i(ea), .serial_busy_i(busy), .core_reset_o(crst),
    .serial_reset_o(srst), .req_i(req), .req_code_i(code),
    .req_we_i(we), .req_addr_i(addr), .req_wdata_i({3{wd}}),
    .req_grant_o(grant), .req_done_o(done), .req_rdata_o(rdata),
    .port_wr_i(pwr), .port_bit_i(pbit), .port_sel_i(psel),
    .port_bit_idx_i(pidx), .port_wdata_i(pwd), .port_rdata_o(prd),
    .iram_we_i(iwe), .iram_addr_i(iad), .iram_wdata_i(iwd),
    .iram_rdata_o(ird), .iram_region_o(rgn), .ale_o(ale),
    .main_fetch_strobe_n_o(mn), .alt_fetch_strobe_n_o(an),
    .pin_i(pi), .pin_o(po), .pin_oe_o(poe));
  pfbs_mem u_pfbs_mem (.mclk_i(mclk_i), .ale_i(ale), .main_n_i(mn),
    .alt_n_i(an), .po_i(po), .oe_i(poe), .pi_o(pi));
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] route(input logic [15:0] x);
    return (sev && alt && (!ea || x <= 16'h1fff)) ? 2'h2 : 2'h1;
  endfunction
  function automatic logic [7:0] exp_st(input logic [15:0] x);
    if (code[0])
      return {6'h0, route(x)};
    return {4'h0, we[0], !we[0], 2'h0};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [15:0] x);
    if (!code[0] && we[0])
      return wd;
    return x[7:0] ^ x[15:8] ^ (code[0] ? 8'h5a : 8'ha5);
  endfunction
  task automatic fetch(input logic [2:0] r, input logic [2:0] e);
    @(negedge mclk_i);
    req = req | r;
    addr = {3{a}};
    {sm, sa, sw, sr, g} = 7'h00;
    for (int k = 0; k < 20 && done == 0; k++) begin
      @(negedge mclk_i);
      sm = sm | !mn;
      sa = sa | !an;
      sw = sw | !po[3][6];
      sr = sr | !po[3][7];
      g = g | grant;
    end
    cmp({4'h0, sw, sr, sa, sm}, exp_st(a));
    cmp(rdata, exp_rd(a));
    cmp({2'h0, g, done}, {2'h0, e, e});
    req = req & ~done;
  endtask
  task automatic pwrite(input logic [2:0] s, input logic b,
                        input logic [2:0] x, input logic [7:0] d);
    @(negedge mclk_i);
    {pwr, pbit, psel, pidx, pwd} = {1'b1, b, s, x, d};
    @(negedge mclk_i);
    pwr = 0;
    @(negedge mclk_i);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(negedge mclk_i);
    rst_i = 0;
    for (int i = 0; i < 32; i++) begin
      {sev, alt, ea} = i[2:0];
      a = (i < 8) ? 16'h1fff : (i < 16) ? 16'h2000 : 16'($random(seed));
      fetch(3'h4, 3'h4);
    end
    {sev, alt, ea} = 3'h0;
    fetch(3'h5, 3'h1);
    fetch(3'h0, 3'h4);
    code = 3'h0;
    for (int i = 0; i < 6; i++) begin
      {sev, alt, ea} = {2'h3, i[1]};
      we = {3{i[0]}};
      wd = 8'($random(seed));
      a = 16'($random(seed));
      fetch(3'h2, 3'h2);
    end
    code = 3'h7;
    we = 3'h0;
    sev = 1;
    pwrite(3'h5, 1, 3'h3, 8'h00);
    cmp(poe[5], 8'h00);
    pwrite(3'h1, 1, 3'h3, 8'h00);
    cmp(poe[1], 8'h08);
    for (int p = 0; p < 7; p++) begin
      v = 8'($random(seed));
      pwrite(p[2:0], 0, 3'h0, v);
      cmp(poe[p], ~v);
      cmp(prd, v);
    end
    for (int i = 0; i < 12; i++) begin
      @(negedge mclk_i);
      iad = (i < 4) ? 8'h1f + 8'(i[1] * 96 + i[0]) : 8'($random(seed));
      iwd = 8'($random(seed));
      iwe = 1;
      @(negedge mclk_i);
      iwe = 0;
      v = (iad < 8'h20) ? 8'h00 : (iad < 8'h80) ? 8'h01 : 8'h02;
      cmp({6'h0, rgn}, v);
      @(negedge mclk_i);
      cmp(ird, iwd);
    end
    busy = 1;
    rpin = 0;
    repeat (20) @(negedge mclk_i);
    cmp({7'h0, crst}, 8'h00);
    repeat (30) @(negedge mclk_i);
    cmp({6'h0, crst, srst}, 8'h02);
    busy = 0;
    repeat (2) @(negedge mclk_i);
    cmp({6'h0, crst, srst}, 8'h03);
    rpin = 1;
    repeat (15) @(negedge mclk_i);
    cmp({7'h0, crst}, 8'h00);
    summarize();
  end
endmodule // pfbs_top_tb
